/* File: audio_chan_pkg.sv */
/*
  Shared constants and types for the serial audio channel data path:
  register offsets, control field layout, reset values, sample width codes,
  link input positions and the transmit fetch sequencer states.
  Assumes a 32-bit register port and a link clock that is much slower than clk_sys.
*/
package audio_chan_pkg;

  // Register offsets on the plain register port (byte addresses).
  localparam logic [7:0] OFF_TX_CTRL = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL = 8'h04;
  localparam logic [7:0] OFF_TX_DATA = 8'h08;
  localparam logic [7:0] OFF_RX_DATA = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Control field positions inside a control word.
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_MUTE_BIT = 1;
  localparam int CTRL_MONO_BIT = 2;
  localparam int CTRL_WIDTH_LSB = 3;
  localparam int CTRL_RESET_BIT = 5;
  localparam int CTRL_BITS = 6;

  // Status field positions: transmit level low, receive level from bit 8.
  localparam int STAT_TX_LSB = 0;
  localparam int STAT_RX_LSB = 8;

  // Sample width codes.
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h3;

  // Documented FIFO depth in 32-bit words.
  localparam int FIFO_DEPTH = 8;

  // Positions of the link inputs inside the synchroniser vector.
  localparam int LINK_TX_SCK = 0;
  localparam int LINK_TX_WS = 1;
  localparam int LINK_RX_SCK = 2;
  localparam int LINK_RX_WS = 3;
  localparam int LINK_RX_SD = 4;
  localparam int LINK_INPUTS = 5;

  // Channel control word; field order matches the bit positions above.
  typedef struct packed {
    logic reset;
    logic [1:0] width;
    logic mono;
    logic mute;
    logic stop;
  } ctrl_t;

  // Reset value of a control word: stopped, muted, stereo, 32-bit samples.
  localparam ctrl_t CTRL_RESET = '{reset: 1'b0, width: WIDTH_32, mono: 1'b0, mute: 1'b1, stop: 1'b1};

  // Transmit fetch sequencer, one-hot.
  typedef enum logic [2:0] {
    FETCH_IDLE = 3'b001,
    FETCH_LEFT = 3'b010,
    FETCH_RIGHT = 3'b100
  } fetch_t;

endpackage

/* File: link_sync.sv */
/*
  Three-stage synchroniser for link inputs with agreement filter and edge pulses.
  Assumes inputs come from outside the clk_sys domain and change slowly
  compared with clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module link_sync #(
  parameter int W = 1
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Raw inputs.
  input wire logic [W-1:0] d,
  // Filtered level and one-cycle edge pulses.
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // All state of the synchroniser.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  // Next state: the level changes only where stages two and three agree.
  always_comb begin
    s_next = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.q = (s_reg.s2 & s_reg.s3) | (s_reg.q & (s_reg.s2 ^ s_reg.s3));
    s_next.rise = s_next.q & ~s_reg.q;
    s_next.fall = ~s_next.q & s_reg.q;
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;
  assign rise = s_reg.rise;
  assign fall = s_reg.fall;

endmodule // link_sync

`default_nettype wire

/* File: audio_chan.sv */
/*
  Transmit and receive channel data path of a serial audio interface:
  two word FIFOs, stop and mute, sample width and mono packing, underrun
  repeat, and word-select timed loading and capture.
  Assumes the codec drives bit clocks and word selects; they are sampled by clk_sys,
  which must run well above twice the bit rate.
*/
`timescale 1ns/1ps
`default_nettype none

module audio_chan #(
  parameter int DEPTH = audio_chan_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Transmit link.
  input wire logic tx_sck,
  input wire logic tx_ws,
  output logic tx_sd,
  // Receive link.
  input wire logic rx_sck,
  input wire logic rx_ws,
  input wire logic rx_sd
);

  localparam int AW = $clog2(DEPTH);

  // The pointers wrap by overflow, so the depth must be a power of two.
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("DEPTH must be a power of two of at least 2");
    end
  endgenerate

  // All state of the channel pair.
  typedef struct packed {
    audio_chan_pkg::ctrl_t txc;       // Transmit control.
    audio_chan_pkg::ctrl_t rxc;       // Receive control.
    logic [DEPTH-1:0][31:0] tx_mem;   // Transmit FIFO storage.
    logic [DEPTH-1:0][31:0] rx_mem;   // Receive FIFO storage.
    logic [AW-1:0] tx_wp;             // Transmit write pointer.
    logic [AW-1:0] tx_rp;             // Transmit read pointer.
    logic [AW:0] tx_cnt;              // Transmit fill level.
    logic [AW-1:0] rx_wp;             // Receive write pointer.
    logic [AW-1:0] rx_rp;             // Receive read pointer.
    logic [AW:0] rx_cnt;              // Receive fill level.
    logic [1:0] tx_pos;               // Next sample slot in the transmit head word.
    audio_chan_pkg::fetch_t fetch;    // Transmit fetch sequencer.
    logic [31:0] pend_l;              // Fetched left sample, left-justified.
    logic [31:0] pend_r;              // Fetched right sample, left-justified.
    logic [31:0] hold_l;              // Left sample handed to the link side.
    logic [31:0] hold_r;              // Right sample handed to the link side.
    logic [31:0] shift;               // Transmit shift register, MSB out first.
    logic tx_ws_prev;                 // Word select at the last transmit bit.
    logic tx_sd;                      // Registered serial output.
    logic rx_ws_prev;                 // Word select at the last received bit.
    logic rx_live;                    // A word-select change has been seen.
    logic [31:0] rx_sh;               // Receive shift register.
    logic [5:0] rx_bits;              // Bits captured in the current sample.
    logic [1:0] rx_pos;               // Next sample slot in the receive word.
    logic [31:0] rx_acc;              // Receive word being assembled.
    logic [31:0] rdata;               // Registered read data.
  } state_t;

  state_t s_reg;
  state_t s_next;

  // Synchronised link inputs.
  logic [audio_chan_pkg::LINK_INPUTS-1:0] link_q;
  logic [audio_chan_pkg::LINK_INPUTS-1:0] link_rise;
  logic [audio_chan_pkg::LINK_INPUTS-1:0] link_fall;

  // Index of the last sample slot in a word for a width code.
  function automatic logic [1:0] last_slot(input logic [1:0] wd);
    unique case (wd)
      audio_chan_pkg::WIDTH_8: last_slot = 2'h3;
      audio_chan_pkg::WIDTH_16: last_slot = 2'h1;
      default: last_slot = 2'h0;
    endcase
  endfunction

  // Number of bits in one sample for a width code.
  function automatic logic [5:0] sample_bits(input logic [1:0] wd);
    unique case (wd)
      audio_chan_pkg::WIDTH_8: sample_bits = 6'h08;
      audio_chan_pkg::WIDTH_16: sample_bits = 6'h10;
      default: sample_bits = 6'h20;
    endcase
  endfunction

  // Extract one sample from a word and left-justify it for shifting out.
  function automatic logic [31:0] take(input logic [31:0] w, input logic [1:0] p, input logic [1:0] wd);
    unique case (wd)
      audio_chan_pkg::WIDTH_8: take = {w[{p, 3'h0} +: 8], 24'h000000};
      audio_chan_pkg::WIDTH_16: take = {w[{p[0], 4'h0} +: 16], 16'h0000};
      default: take = w;
    endcase
  endfunction

  // Place a right-justified received sample into its slot of a word.
  function automatic logic [31:0] pack(input logic [31:0] acc, input logic [31:0] v, input logic [1:0] p,
                                       input logic [1:0] wd);
    logic [31:0] r;
    r = acc;
    unique case (wd)
      audio_chan_pkg::WIDTH_8: r[{p, 3'h0} +: 8] = v[7:0];
      audio_chan_pkg::WIDTH_16: r[{p[0], 4'h0} +: 16] = v[15:0];
      default: r = v;
    endcase
    return r;
  endfunction

  // Link clocks, word selects and receive data cross into clk_sys here.
  link_sync #(
    .W(audio_chan_pkg::LINK_INPUTS)
  ) u_link_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .d({rx_sd, rx_ws, rx_sck, tx_ws, tx_sck}),
    .q(link_q),
    .rise(link_rise),
    .fall(link_fall)
  );

  // Next-state logic for the register port, both FIFOs and both channels.
  always_comb begin
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic deliver;
    logic ws;
    logic [31:0] rx_word;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    deliver = 1'b0;
    ws = 1'b0;
    rx_word = s_reg.rx_acc;
    s_next = s_reg;

    // Register writes; FIFO data are always whole words.
    if (reg_wr) begin
      unique case (reg_addr)
        audio_chan_pkg::OFF_TX_CTRL: begin
          s_next.txc = audio_chan_pkg::ctrl_t'(reg_wdata[audio_chan_pkg::CTRL_BITS-1:0]);
        end
        audio_chan_pkg::OFF_RX_CTRL: begin
          s_next.rxc = audio_chan_pkg::ctrl_t'(reg_wdata[audio_chan_pkg::CTRL_BITS-1:0]);
        end
        audio_chan_pkg::OFF_TX_DATA: begin
          if (s_reg.tx_cnt != (AW + 1)'(DEPTH)) begin
            tx_push = 1'b1;
            s_next.tx_mem[s_reg.tx_wp] = reg_wdata;
          end
        end
        default: begin
          // Writes elsewhere are ignored.
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped offsets read zero.
    s_next.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        audio_chan_pkg::OFF_TX_CTRL: s_next.rdata = {26'h0000000, s_reg.txc};
        audio_chan_pkg::OFF_RX_CTRL: s_next.rdata = {26'h0000000, s_reg.rxc};
        audio_chan_pkg::OFF_RX_DATA: begin
          // whole word pop; an empty FIFO reads zero.
          if (s_reg.rx_cnt != '0) begin
            rx_pop = 1'b1;
            s_next.rdata = s_reg.rx_mem[s_reg.rx_rp];
          end
        end
        audio_chan_pkg::OFF_STATUS: begin
          s_next.rdata[audio_chan_pkg::STAT_TX_LSB +: AW + 1] = s_reg.tx_cnt;
          s_next.rdata[audio_chan_pkg::STAT_RX_LSB +: AW + 1] = s_reg.rx_cnt;
        end
        default: begin
          s_next.rdata = 32'h00000000;
        end
      endcase
    end

    // Transmit fetch: one sample slot per step, popping a word once it is used up.
    unique case (s_reg.fetch)
      audio_chan_pkg::FETCH_LEFT: begin
        s_next.fetch = audio_chan_pkg::FETCH_RIGHT;
        // stop blocks reads; empty keeps last sample.
        if (!s_reg.txc.stop && s_reg.tx_cnt != '0) begin
          // slot extraction by width; read even when muted.
          s_next.pend_l = take(s_reg.tx_mem[s_reg.tx_rp], s_reg.tx_pos, s_reg.txc.width);
          if (s_reg.tx_pos == last_slot(s_reg.txc.width)) begin
            s_next.tx_pos = 2'h0;
            tx_pop = 1'b1;
          end else begin
            s_next.tx_pos = s_reg.tx_pos + 2'h1;
          end
        end else begin
          s_next.fetch = audio_chan_pkg::FETCH_IDLE;
        end
      end
      audio_chan_pkg::FETCH_RIGHT: begin
        s_next.fetch = audio_chan_pkg::FETCH_IDLE;
        if (s_reg.txc.mono) begin
          // Mono sends the same sample on both sides.
          s_next.pend_r = s_reg.pend_l;
        end else if (!s_reg.txc.stop && s_reg.tx_cnt != '0) begin
          // next slot is right; a second word in 32-bit stereo.
          s_next.pend_r = take(s_reg.tx_mem[s_reg.tx_rp], s_reg.tx_pos, s_reg.txc.width);
          if (s_reg.tx_pos == last_slot(s_reg.txc.width)) begin
            s_next.tx_pos = 2'h0;
            tx_pop = 1'b1;
          end else begin
            s_next.tx_pos = s_reg.tx_pos + 2'h1;
          end
        end
      end
      audio_chan_pkg::FETCH_IDLE: begin
        s_next.fetch = audio_chan_pkg::FETCH_IDLE;
      end
    endcase

    // Transmit link: a new bit on each bit clock falling edge.
    if (link_fall[audio_chan_pkg::LINK_TX_SCK]) begin
      ws = link_q[audio_chan_pkg::LINK_TX_WS];
      if (ws != s_reg.tx_ws_prev) begin
        s_next.tx_ws_prev = ws;
        if (!ws) begin
          // left loads on falling word select.
          s_next.shift = s_reg.hold_l;
          // fetch starts after falling word select.
          s_next.fetch = audio_chan_pkg::FETCH_LEFT;
        end else begin
          // right loads on rising word select.
          s_next.shift = s_reg.hold_r;
          // fetched pair moves to the link side.
          s_next.hold_l = s_reg.pend_l;
          s_next.hold_r = s_reg.pend_r;
        end
      end else begin
        s_next.shift = {s_reg.shift[30:0], 1'b0};
      end
      s_next.tx_sd = (s_reg.txc.mute || s_reg.txc.stop) ? 1'b0 : s_next.shift[31];
    end

    // Receive link: a bit on each bit clock rising edge; mute is not looked at.
    if (link_rise[audio_chan_pkg::LINK_RX_SCK]) begin
      ws = link_q[audio_chan_pkg::LINK_RX_WS];
      if (ws != s_reg.rx_ws_prev) begin
        // restart on change; low word select is left.
        s_next.rx_ws_prev = ws;
        s_next.rx_live = 1'b1;
        s_next.rx_sh = {31'h00000000, link_q[audio_chan_pkg::LINK_RX_SD]};
        s_next.rx_bits = 6'h01;
        // delivery needs rx_live and no stop, and ignores mute; mono keeps left words.
        deliver = s_reg.rx_live && !s_reg.rxc.stop && (!s_reg.rxc.mono || !s_reg.rx_ws_prev);
      end else if (s_reg.rx_bits < sample_bits(s_reg.rxc.width)) begin
        // capture only up to the width limit.
        s_next.rx_sh = {s_reg.rx_sh[30:0], link_q[audio_chan_pkg::LINK_RX_SD]};
        s_next.rx_bits = s_reg.rx_bits + 6'h01;
      end
    end

    // finished sample stored; full word pushed.
    if (deliver) begin
      rx_word = pack(s_reg.rx_acc, s_reg.rx_sh, s_reg.rx_pos, s_reg.rxc.width);
      s_next.rx_acc = rx_word;
      if (s_reg.rx_pos == last_slot(s_reg.rxc.width)) begin
        s_next.rx_pos = 2'h0;
        // a full FIFO drops the word unless a read pops in the same cycle.
        if (s_reg.rx_cnt != (AW + 1)'(DEPTH) || rx_pop) begin
          rx_push = 1'b1;
          s_next.rx_mem[s_reg.rx_wp] = rx_word;
        end
      end else begin
        s_next.rx_pos = s_reg.rx_pos + 2'h1;
      end
    end

    // Pointer and level bookkeeping for both FIFOs.
    s_next.tx_wp = s_reg.tx_wp + AW'(tx_push);
    s_next.tx_rp = s_reg.tx_rp + AW'(tx_pop);
    s_next.tx_cnt = s_reg.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
    s_next.rx_wp = s_reg.rx_wp + AW'(rx_push);
    s_next.rx_rp = s_reg.rx_rp + AW'(rx_pop);
    s_next.rx_cnt = s_reg.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);

    // transmit channel reset empties and resynchronises it.
    if (s_next.txc.reset) begin
      s_next.txc.reset = 1'b0;
      s_next.tx_wp = '0;
      s_next.tx_rp = '0;
      s_next.tx_cnt = '0;
      s_next.tx_pos = 2'h0;
      s_next.fetch = audio_chan_pkg::FETCH_IDLE;
      s_next.pend_l = 32'h00000000;
      s_next.pend_r = 32'h00000000;
      s_next.hold_l = 32'h00000000;
      s_next.hold_r = 32'h00000000;
      s_next.shift = 32'h00000000;
      s_next.tx_sd = 1'b0;
    end

    // receive channel reset empties and resynchronises it.
    if (s_next.rxc.reset) begin
      s_next.rxc.reset = 1'b0;
      s_next.rx_wp = '0;
      s_next.rx_rp = '0;
      s_next.rx_cnt = '0;
      s_next.rx_pos = 2'h0;
      s_next.rx_live = 1'b0;
      s_next.rx_sh = 32'h00000000;
      s_next.rx_bits = 6'h00;
      s_next.rx_acc = 32'h00000000;
    end
  end

  // State register with synchronous reset, frozen while the enable is low.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.txc <= audio_chan_pkg::CTRL_RESET;
      s_reg.rxc <= audio_chan_pkg::CTRL_RESET;
      s_reg.fetch <= audio_chan_pkg::FETCH_IDLE;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata = s_reg.rdata;
  assign tx_sd = s_reg.tx_sd;

endmodule // audio_chan

`default_nettype wire

/* File: audio_chan_asserts.sv */
/*
  Concurrent checks on the ports of the audio channel block.
  Assumes it is bound to the top module and that clk_sys is its only clock.
*/
`timescale 1ns/1ps
`default_nettype none

module audio_chan_asserts #(
  parameter int DEPTH = audio_chan_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Transmit link.
  input wire logic tx_sck,
  input wire logic tx_ws,
  input wire logic tx_sd,
  // Receive link.
  input wire logic rx_sck,
  input wire logic rx_ws,
  input wire logic rx_sd
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Control words as last written, without the self-clearing reset bit.
  audio_chan_pkg::ctrl_t tx_c;
  audio_chan_pkg::ctrl_t rx_c;
  // Cycles since the last bit clock fall and since the last transmit control write.
  logic [3:0] fall_age;
  logic [3:0] ctrl_age;

  // Keeps the shadows and the two saturating ages.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_c <= audio_chan_pkg::CTRL_RESET;
      rx_c <= audio_chan_pkg::CTRL_RESET;
      fall_age <= 4'hf;
      ctrl_age <= 4'hf;
    end else begin
      if (ce && reg_wr && reg_addr == audio_chan_pkg::OFF_TX_CTRL) begin
        tx_c <= audio_chan_pkg::ctrl_t'({1'b0, reg_wdata[4:0]});
      end
      if (ce && reg_wr && reg_addr == audio_chan_pkg::OFF_RX_CTRL) begin
        rx_c <= audio_chan_pkg::ctrl_t'({1'b0, reg_wdata[4:0]});
      end
      fall_age <= $fell(tx_sck) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
      ctrl_age <= (reg_wr && reg_addr == audio_chan_pkg::OFF_TX_CTRL) ? 4'h0 : ctrl_age + {3'h0, ctrl_age != 4'hf};
    end
  end

  // Stop or mute held long enough for the line to settle.
  sequence stop_held;
    tx_c.stop [*8];
  endsequence
  sequence mute_held;
    tx_c.mute [*8];
  endsequence
  // A control read answers with the word last written.
  property ctrl_echo(logic [7:0] a, audio_chan_pkg::ctrl_t c);
    reg_rd && reg_addr == a |=> reg_rdata == {26'h0, c};
  endproperty

  rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  tx_ctrl_echo_a: assert property (ctrl_echo(audio_chan_pkg::OFF_TX_CTRL, tx_c))
    else $error("transmit control read back wrong");
  rx_ctrl_echo_a: assert property (ctrl_echo(audio_chan_pkg::OFF_RX_CTRL, rx_c))
    else $error("receive control read back wrong");
  level_bound_a: assert property (reg_rd && reg_addr == audio_chan_pkg::OFF_STATUS |=>
      reg_rdata[7:0] <= 8'(DEPTH) && reg_rdata[15:8] <= 8'(DEPTH))
    else $error("fifo level above depth");
  unmapped_read_a: assert property (reg_rd && reg_addr > 8'h13 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  stop_quiet_a: assert property (stop_held ##0 fall_age == 4'h6 |-> !tx_sd)
    else $error("transmit line active while stopped");
  mute_quiet_a: assert property (mute_held ##0 fall_age == 4'h6 |-> !tx_sd)
    else $error("transmit line active while muted");
  sd_timing_a: assert property ($changed(tx_sd) && ctrl_age > 4'h4 |-> fall_age inside {[4'h1:4'h8]})
    else $error("transmit data changed away from a bit clock fall");

endmodule // audio_chan_asserts

`default_nettype wire

/* File: codec_model.sv */
/*
  Behavioural codec: makes the bit clock and word select, sends receive data
  and captures transmit data. Assumes the bench calls frame() for each frame.
*/
`timescale 1ns/1ps
`default_nettype none

module codec_model (
  // Link lines to the block.
  output logic sck,
  output logic ws,
  output logic sd_out,
  input wire logic sd_in
);
  // Words captured from the transmit line in the last frame.
  logic [31:0] cap_l;
  logic [31:0] cap_r;

  // Idle: clock high and still, word select high.
  initial begin
    sck = 1'b1;
    ws = 1'b1;
    sd_out = 1'b0;
  end

  // One stereo frame of 64 bits at 400 ns each; the clock stops after it.
  task automatic frame(input logic [31:0] l, input logic [31:0] r);
    logic [63:0] tx;
    logic [63:0] rx;
    tx = {l, r};
    for (int i = 0; i < 64; i++) begin
      sck = 1'b0;
      ws = (i >= 32);
      sd_out = tx[63 - i];
      #200;
      sck = 1'b1;
      #199;
      rx[63 - i] = sd_in;
      #1;
    end
    {cap_l, cap_r} = rx;
    // The released line shows the inverse of its last bit.
    sd_out = ~sd_out;
  endtask
endmodule // codec_model

`default_nettype wire

/* File: tb_top.sv */
/*
  Bench top: clock, reset, register tasks, scenarios and verdict.
  Assumes the codec model drives both link clocks and word selects.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int DEPTH = audio_chan_pkg::FIFO_DEPTH;
  // Clock, reset and register port.
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // Link lines; clock and word select are shared by both directions.
  logic sck;
  logic ws;
  logic sd_rx;
  logic tx_sd;
  // Tallies, frame number and cycle count.
  int failures = 0;
  int comparisons = 0;
  int fr = 0;
  int cycles = 0;

  // The clock toggles every 25 ns.
  always #25 clk_sys = ~clk_sys;

  audio_chan #(.DEPTH(DEPTH)) uut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_sck(sck),
    .tx_ws(ws), .tx_sd(tx_sd), .rx_sck(sck), .rx_ws(ws), .rx_sd(sd_rx));
  codec_model codec (.sck(sck), .ws(ws), .sd_out(sd_rx), .sd_in(tx_sd));

  // Ends the run with the verdict.
  task automatic final_report;
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  // Compares one word and counts the outcome.
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write: one cycle with the strobe high.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read: the data stands in the cycle after the strobe.
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  // Control word from its fields.
  function automatic logic [31:0] cw(input int rst, input int w, input int mono, input int mute, input int stop);
    return 32'(rst * 32 + w * 8 + mono * 4 + mute * 2 + stop);
  endfunction

  // Receive word number n sent by the codec.
  function automatic logic [31:0] rxw(input int n);
    return {8'(n), 8'ha5, 8'(n), 8'h3c};
  endfunction

  // One frame with numbered receive words.
  task automatic run_frame;
    codec.frame(rxw(2 * fr), rxw(2 * fr + 1));
    fr++;
  endtask

  // Reset values, an unmapped place and an empty read.
  task automatic reset_values;
    logic [31:0] d;
    reg_read(audio_chan_pkg::OFF_TX_CTRL, d);
    check("tx_ctrl", 32'h1b, d);
    reg_read(audio_chan_pkg::OFF_RX_CTRL, d);
    check("rx_ctrl", 32'h1b, d);
    reg_write(8'h14, 32'hffff_ffff);
    reg_read(8'h14, d);
    check("unmapped", 32'h0, d);
    // Enable low: the write is lost.
    @(posedge clk_sys);
    ce <= 1'b0;
    reg_write(audio_chan_pkg::OFF_TX_CTRL, 32'h0);
    ce <= 1'b1;
    reg_read(audio_chan_pkg::OFF_TX_CTRL, d);
    check("ce_hold", 32'h1b, d);
    reg_read(audio_chan_pkg::OFF_RX_DATA, d);
    check("rx_empty", 32'h0, d);
  endtask

  // Stop leaves both FIFOs untouched and the left slot quiet.
  task automatic stop_blocks;
    logic [31:0] d;
    reg_write(audio_chan_pkg::OFF_TX_DATA, 32'h1111_1111);
    reg_write(audio_chan_pkg::OFF_TX_DATA, 32'h2222_2222);
    run_frame();
    run_frame();
    reg_read(audio_chan_pkg::OFF_STATUS, d);
    check("status", 32'h2, d);
    check("tx_left", 32'h0, codec.cap_l);
  endtask

  // Stereo words, underrun repeat and receive order.
  task automatic stereo_words;
    logic [31:0] d;
    int b;
    b = fr;
    reg_write(audio_chan_pkg::OFF_TX_CTRL, cw(1, audio_chan_pkg::WIDTH_32, 0, 0, 1));
    reg_write(audio_chan_pkg::OFF_RX_CTRL, cw(1, audio_chan_pkg::WIDTH_32, 0, 0, 0));
    for (int i = 1; i <= 4; i++) begin
      reg_write(audio_chan_pkg::OFF_TX_DATA, 32'h0c0c_0000 + 32'(i));
    end
    reg_write(audio_chan_pkg::OFF_TX_CTRL, cw(0, audio_chan_pkg::WIDTH_32, 0, 0, 0));
    for (int f = 0; f < 4; f++) begin
      run_frame();
      if (f > 0) begin
        check("tx_left", f == 1 ? 32'h0c0c_0001 : 32'h0c0c_0003, codec.cap_l);
        check("tx_right", f == 1 ? 32'h0c0c_0002 : 32'h0c0c_0004, codec.cap_r);
      end
    end
    reg_read(audio_chan_pkg::OFF_STATUS, d);
    check("status", 32'h700, d);
    for (int k = 0; k < 7; k++) begin
      reg_read(audio_chan_pkg::OFF_RX_DATA, d);
      check("rx_word", rxw(2 * b + k), d);
    end
  endtask

  // Mute drains the transmit FIFO into zeroes while reception goes on.
  task automatic mute_consumes;
    logic [31:0] d;
    reg_write(audio_chan_pkg::OFF_TX_CTRL, cw(0, audio_chan_pkg::WIDTH_32, 0, 1, 0));
    reg_write(audio_chan_pkg::OFF_TX_DATA, 32'h7777_0001);
    reg_write(audio_chan_pkg::OFF_TX_DATA, 32'h7777_0002);
    run_frame();
    check("tx_left", 32'h0, codec.cap_l);
    check("tx_right", 32'h0, codec.cap_r);
    reg_read(audio_chan_pkg::OFF_STATUS, d);
    check("status", 32'h200, d);
  endtask

  // Width and mono packing; the 16-bit and 32-bit mono runs go into an underrun, the 8-bit run does not.
  task automatic width_modes;
    logic [31:0] d;
    int b;
    logic [1:0] wd [3] = '{audio_chan_pkg::WIDTH_16, audio_chan_pkg::WIDTH_8, audio_chan_pkg::WIDTH_32};
    logic [31:0] word [3] = '{32'h1234_abcd, 32'h4433_2211, 32'hfeed_0001};
    logic [31:0] ex [3][4] = '{'{32'habcd_0000, 32'h1234_0000, 32'habcd_0000, 32'h1234_0000},
      '{32'h1100_0000, 32'h2200_0000, 32'h3300_0000, 32'h4400_0000},
      '{32'hfeed_0001, 32'hfeed_0001, 32'hfeed_0001, 32'hfeed_0001}};
    for (int m = 0; m < 3; m++) begin
      reg_write(audio_chan_pkg::OFF_TX_CTRL, cw(1, wd[m], int'(m == 2), 0, 1));
      reg_write(audio_chan_pkg::OFF_RX_CTRL, cw(1, wd[m], int'(m == 2), 0, 0));
      reg_write(audio_chan_pkg::OFF_TX_DATA, word[m]);
      reg_write(audio_chan_pkg::OFF_TX_CTRL, cw(0, wd[m], int'(m == 2), 0, 0));
      b = fr;
      for (int f = 0; f < 3; f++) begin
        run_frame();
        if (f > 0) begin
          check("tx_left", ex[m][2 * f - 2], codec.cap_l);
          check("tx_right", ex[m][2 * f - 1], codec.cap_r);
        end
      end
      if (m != 1) begin
        reg_read(audio_chan_pkg::OFF_STATUS, d);
        check("status", m == 0 ? 32'h200 : 32'h300, d);
        for (int k = 0; k < 2 + m / 2; k++) begin
          reg_read(audio_chan_pkg::OFF_RX_DATA, d);
          check("rx_word", m == 0 ? {8'(2 * b + 2 * k + 1), 8'ha5, 8'(2 * b + 2 * k), 8'ha5} :
            rxw(2 * b + 2 * k), d);
        end
      end
    end
  endtask

  // Reset for 12 cycles, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    reset_values();
    stop_blocks();
    stereo_words();
    mute_consumes();
    width_modes();
    final_report();
  end
endmodule // tb_top

bind audio_chan audio_chan_asserts #(.DEPTH(DEPTH)) chk (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_sck(tx_sck), .tx_ws(tx_ws), .tx_sd(tx_sd), .rx_sck(rx_sck), .rx_ws(rx_ws), .rx_sd(rx_sd));

`default_nettype wire
